/* File: hw/ersl_consts.svh */
// Function
// - codes 0x00 none, 0x01 impl, 0x02 internal ram
// - codes 0x03 pin, 0x04 assertion, 0x05 datapath
// - codes 0x06-0x09 associative memory and translation buffer
// - codes 0x0A-0x0B producer, 0x0C external memory
// - codes 0x0D-0x0F software address, access, state
// - codes 0x10 data register, 0x11 control register
// - codes 0x12 completer response, 0x13-0x14 timeouts
// - codes 0x15-0x18 deferred errors, stopped or passed
// - codes 0x19 pcie log, 0x1A other internal
// - code cleared to 0x00 on cold reset, kept on recovery
// - one-bit and two-bit flags are write-one-to-clear
// - subcode and primary code are read/write
// - v1.0: overflow set blocks status flag writes
// - v1.0: record-valid kept while status flags remain
// - v1.0: syndrome kept unless top flag cleared
// - v1.1: whole write dropped unless valid, overflow and status flags all cleared
// - candidate: high and low written, middle cleared
// - id register 0 read-only at 0xFF0
// - id register 0 bits 7:0 read 0x0D
// - corrected kind bits 25:24, four encodings
// - subcode bits 15:8 qualifies any primary code
`ifndef ERSL_CONSTS_SVH
`define ERSL_CONSTS_SVH

`define ERSL_ADDR_W          12
`define ERSL_STATUS_OFFSET   12'h010
`define ERSL_CID0_OFFSET     12'hff0
`define ERSL_CID0_PREAMBLE   8'h0d
`define ERSL_CID0_PRESENT    1'b1

`define ERSL_CODE_NONE       8'h00
`define ERSL_CODE_IMPL       8'h01
`define ERSL_CODE_INT_MEM    8'h02
`define ERSL_CODE_PIN        8'h03
`define ERSL_CODE_ASSERT     8'h04
`define ERSL_CODE_DATAPATH   8'h05
`define ERSL_CODE_ASSOC_DATA 8'h06
`define ERSL_CODE_ASSOC_CTRL 8'h07
`define ERSL_CODE_XLAT_DATA  8'h08
`define ERSL_CODE_XLAT_CTRL  8'h09
`define ERSL_CODE_PROD_DATA  8'h0a
`define ERSL_CODE_PROD_CTRL  8'h0b
`define ERSL_CODE_EXT_MEM    8'h0c
`define ERSL_CODE_SW_ADDR    8'h0d
`define ERSL_CODE_SW_ACCESS  8'h0e
`define ERSL_CODE_SW_STATE   8'h0f
`define ERSL_CODE_DATA_REG   8'h10
`define ERSL_CODE_CTRL_REG   8'h11
`define ERSL_CODE_COMPL_RESP 8'h12
`define ERSL_CODE_EXT_TMO    8'h13
`define ERSL_CODE_INT_TMO    8'h14
`define ERSL_CODE_DEF_CMP_NS 8'h15
`define ERSL_CODE_DEF_REQ_NS 8'h16
`define ERSL_CODE_DEF_CMP_PT 8'h17
`define ERSL_CODE_DEF_REQ_PT 8'h18
`define ERSL_CODE_PCIE_LOG   8'h19
`define ERSL_CODE_OTHER      8'h1a
`define ERSL_CODE_LAST       8'h1a

`define ERSL_CE_NONE         2'h0
`define ERSL_CE_TRANSIENT    2'h1
`define ERSL_CE_UNSPEC       2'h2
`define ERSL_CE_PERSISTENT   2'h3

`define ERSL_SYNC_STAGES     3

`endif

/* File: hw/ersl_pkg.sv */
package ersl_pkg;

  typedef struct packed {
    logic [31:0] upper;
    logic        addr_valid_flag;
    logic        record_valid;
    logic        uncorrected_flag;
    logic        restart_needed_flag;
    logic        overflow_flag;
    logic        misc_valid_flag;
    logic [1:0]  corrected_kind;
    logic        postponed_flag;
    logic        poison_flag;
    logic [1:0]  uncorr_kind;
    logic        critical_flag;
    logic [2:0]  rsv;
    logic [7:0]  impl_subcode;
    logic [7:0]  primary_code;
  } ersl_status_s;

  typedef struct packed {
    logic        valid;
    logic        uncorrected;
    logic        postponed;
    logic [1:0]  corrected_kind;
    logic        restart_needed;
    logic        poison;
    logic [1:0]  uncorr_kind;
    logic        critical;
    logic        addr_valid;
    logic        misc_valid;
    logic [7:0]  impl_subcode;
    logic [7:0]  primary_code;
  } ersl_event_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [63:0] wdata;
  } ersl_acc_s;

  typedef struct packed {
    ersl_status_s status;
    logic [63:0]  rd_data;
    logic         rd_valid;
    logic         wr_ignored;
  } ersl_state_s;

  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } ersl_sync_s;

endpackage

/* File: hw/ersl_record.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ersl_consts.svh"
module ersl_record
  import ersl_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         recovery_resetn,
  input  wire logic         arch_v11_pin,
  input  wire ersl_acc_s    acc,
  input  wire ersl_event_s  err_event,
  output logic [63:0]       rd_data,
  output logic              rd_valid,
  output logic              wr_ignored,
  output logic              record_valid,
  output logic              overflow,
  output logic              sys_error_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  ersl_state_s q;
  ersl_state_s next_q;
  logic        arch_v11;

  ersl_sync u_variant_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin_in (arch_v11_pin),
    .level  (arch_v11)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic is_status_addr(input logic [11:0] addr);
    is_status_addr = (addr == `ERSL_STATUS_OFFSET);
  endfunction

  function automatic logic is_cid0_addr(input logic [11:0] addr);
    is_cid0_addr = (addr == `ERSL_CID0_OFFSET);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // field helpers

  function automatic logic any_status(input ersl_status_s s);
    any_status = s.uncorrected_flag | s.postponed_flag | (|s.corrected_kind);
  endfunction

  function automatic logic any_valid(input ersl_status_s s);
    any_valid = s.record_valid | s.uncorrected_flag | s.overflow_flag |
                (|s.corrected_kind) | s.postponed_flag;
  endfunction

  // keep the supported code set on capture, any other captured code reads as other internal
  function automatic logic [7:0] legal_code(input logic [7:0] code);
    if (code > `ERSL_CODE_LAST) begin
      legal_code = `ERSL_CODE_OTHER;
    end else begin
      legal_code = code;
    end
  endfunction

  // stronger corrected kind wins when merging
  function automatic logic [1:0] merge_ce(input logic [1:0] a,
                                          input logic [1:0] b);
    if (a == `ERSL_CE_PERSISTENT || b == `ERSL_CE_PERSISTENT) begin
      merge_ce = `ERSL_CE_PERSISTENT;
    end else if (a == `ERSL_CE_NONE) begin
      merge_ce = b;
    end else if (b == `ERSL_CE_NONE) begin
      merge_ce = a;
    end else if (a == b) begin
      merge_ce = a;
    end else begin
      merge_ce = `ERSL_CE_UNSPEC;
    end
  endfunction

  function automatic logic [1:0] ev_rank(input logic ue, input logic de);
    if (ue) begin
      ev_rank = 2'h2;
    end else if (de) begin
      ev_rank = 2'h1;
    end else begin
      ev_rank = 2'h0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // software write candidate and protection

  ersl_status_s cand;
  ersl_status_s old;
  logic         wr_hit;
  logic         rd_hit_status;
  logic         rd_hit_cid0;
  logic         v11_blocked;

  always_comb begin
    old           = q.status;
    wr_hit        = acc.valid & acc.write & is_status_addr(acc.addr);
    rd_hit_status = acc.valid & ~acc.write & is_status_addr(acc.addr);
    rd_hit_cid0   = acc.valid & ~acc.write & is_cid0_addr(acc.addr);
    v11_blocked   = 1'b0;
    // high and low taken as written, middle flags cleared by ones
    cand = ersl_status_s'({acc.wdata[63:32],
                           old[31:16] & ~acc.wdata[31:16],
                           acc.wdata[15:0]});
    cand.rsv = 3'h0;
    if (arch_v11) begin
      if (any_valid(cand)) begin
        cand        = old;
        v11_blocked = 1'b1;
      end
    end else begin
      if (cand.overflow_flag) begin
        cand.uncorrected_flag = old.uncorrected_flag;
        cand.postponed_flag   = old.postponed_flag;
        cand.corrected_kind   = old.corrected_kind;
      end
      if (any_status(cand)) begin
        cand.record_valid = old.record_valid;
      end
      if (cand.uncorrected_flag ||
          (!old.uncorrected_flag && cand.postponed_flag) ||
          (!old.uncorrected_flag && !old.postponed_flag &&
           (|cand.corrected_kind))) begin
        cand.addr_valid_flag     = old.addr_valid_flag;
        cand.restart_needed_flag = old.restart_needed_flag;
        cand.misc_valid_flag     = old.misc_valid_flag;
        cand.poison_flag         = old.poison_flag;
        cand.critical_flag       = old.critical_flag;
        cand.uncorr_kind         = old.uncorr_kind;
        cand.impl_subcode        = old.impl_subcode;
        cand.primary_code        = old.primary_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: write applied, then capture on top of it

  ersl_status_s after_wr;
  logic         ev_wins;

  always_comb begin
    next_q            = q;
    next_q.rd_valid   = 1'b0;
    next_q.wr_ignored = 1'b0;
    after_wr          = q.status;
    ev_wins           = 1'b0;

    if (wr_hit) begin
      after_wr          = cand;
      next_q.wr_ignored = v11_blocked;
    end

    if (err_event.valid) begin
      // capture takes priority over a same-cycle write
      if (after_wr.record_valid) begin
        after_wr.overflow_flag = 1'b1;
        ev_wins = ev_rank(err_event.uncorrected, err_event.postponed) >
                  ev_rank(after_wr.uncorrected_flag, after_wr.postponed_flag);
      end else begin
        ev_wins = 1'b1;
      end
      after_wr.record_valid     = 1'b1;
      after_wr.uncorrected_flag = after_wr.uncorrected_flag | err_event.uncorrected;
      after_wr.postponed_flag   = after_wr.postponed_flag | err_event.postponed;
      after_wr.corrected_kind   = merge_ce(after_wr.corrected_kind,
                                           err_event.corrected_kind);
      if (ev_wins) begin
        after_wr.addr_valid_flag     = err_event.addr_valid;
        after_wr.misc_valid_flag     = err_event.misc_valid;
        after_wr.restart_needed_flag = err_event.restart_needed;
        after_wr.poison_flag         = err_event.poison;
        after_wr.uncorr_kind         = err_event.uncorr_kind;
        after_wr.critical_flag       = err_event.critical;
        after_wr.impl_subcode        = err_event.impl_subcode;
        after_wr.primary_code        = legal_code(err_event.primary_code);
      end
    end
    next_q.status = after_wr;

    if (rd_hit_status) begin
      next_q.rd_data  = q.status;
      next_q.rd_valid = 1'b1;
    end else if (rd_hit_cid0) begin
      next_q.rd_valid = 1'b1;
      if (`ERSL_CID0_PRESENT) begin
        next_q.rd_data = {56'h0000_0000_0000_00, `ERSL_CID0_PREAMBLE};
      end else begin
        next_q.rd_data = 64'h0000_0000_0000_0000;
      end
    end else if (acc.valid && !acc.write) begin
      next_q.rd_valid = 1'b1;
      next_q.rd_data  = 64'h0000_0000_0000_0000;
    end

    // recovery reset keeps the record, drops the read path
    if (!recovery_resetn) begin
      next_q.status     = q.status;
      next_q.rd_data    = 64'h0000_0000_0000_0000;
      next_q.rd_valid   = 1'b0;
      next_q.wr_ignored = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rd_data       = q.rd_data;
  assign rd_valid      = q.rd_valid;
  assign wr_ignored    = q.wr_ignored;
  assign record_valid  = q.status.record_valid;
  assign overflow      = q.status.overflow_flag;
  assign sys_error_pin = q.status.uncorrected_flag;

endmodule
`default_nettype wire

/* File: hw/ersl_sync.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ersl_consts.svh"
module ersl_sync
  import ersl_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      level
);

  ersl_sync_s q;
  ersl_sync_s next_q;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage chain, level moves when stages two and three agree
  always_comb begin
    next_q = q;
    next_q.stage[0] = pin_in;
    for (int i = 1; i < `ERSL_SYNC_STAGES; i++) begin
      next_q.stage[i] = q.stage[i-1];
    end
    if (q.stage[1] == q.stage[2]) begin
      next_q.level = q.stage[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;

endmodule
`default_nettype wire

/* File: tb/ersl_err_src.sv */
`timescale 1ns/100ps
`default_nettype none
module ersl_err_src
  import ersl_pkg::*;
(
  input  wire logic        fire,
  input  wire ersl_event_s req,
  output var ersl_event_s  err_event
);
  // idle fields flip so stale values are never trusted
  always_comb begin
    err_event       = fire ? req : ~req;
    err_event.valid = fire;
  end
endmodule
`default_nettype wire

/* File: tb/ersl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module ersl_monitor
  import ersl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        recovery_resetn,
  input wire ersl_acc_s   acc,
  input wire ersl_event_s err_event,
  input wire logic [63:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        wr_ignored,
  input wire logic        record_valid,
  input wire logic        overflow,
  input wire logic        sys_error_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_rd;
    acc.valid && !acc.write && recovery_resetn;
  endsequence
  sequence s_wr;
    acc.valid && acc.write && acc.addr == 12'h010 && recovery_resetn && !err_event.valid;
  endsequence
  a_read_answer: assert property (s_rd |=> rd_valid)
    else $error("read not answered");
  a_no_stray: assert property (!(acc.valid && !acc.write) |=> !rd_valid)
    else $error("stray read answer");
  a_id_value: assert property (s_rd ##0 acc.addr == 12'hff0 |=>
    rd_data == 64'h0000_0000_0000_000d) else $error("id value wrong");
  a_clear_all: assert property (s_wr ##0 acc.wdata[31:16] == 16'hffff |=>
    !record_valid && !overflow && !sys_error_pin) else $error("clear failed");
  a_zero_keeps: assert property (s_wr ##0 acc.wdata[31:16] == 16'h0000 |=>
    $stable(record_valid) && $stable(overflow) && $stable(sys_error_pin))
    else $error("zero write changed flags");
  a_drop_keeps: assert property (wr_ignored && !$past(err_event.valid) |->
    $stable(record_valid) && $stable(overflow)) else $error("dropped write applied");
  a_drop_cause: assert property (wr_ignored |-> $past(acc.valid && acc.write))
    else $error("drop without write");
  a_capture_sets: assert property (err_event.valid && recovery_resetn |=>
    record_valid && (sys_error_pin || !$past(err_event.uncorrected)))
    else $error("capture lost");
  a_ovf_merge: assert property (record_valid && err_event.valid && !acc.valid &&
    recovery_resetn |=> overflow) else $error("overflow not set");
  a_recov_holds: assert property (!$past(recovery_resetn) |->
    $stable(record_valid) && $stable(overflow)) else $error("recovery changed record");
endmodule
bind ersl_record ersl_monitor ersl_monitor_i (
  .mclk(mclk), .resetn(resetn), .recovery_resetn(recovery_resetn), .acc(acc),
  .err_event(err_event), .rd_data(rd_data), .rd_valid(rd_valid), .wr_ignored(wr_ignored),
  .record_valid(record_valid), .overflow(overflow), .sys_error_pin(sys_error_pin)
);
`default_nettype wire

/* File: tb/test_error_record_status_logic.sv */
`timescale 1ns/100ps
`default_nettype none
module test_error_record_status_logic
  import ersl_pkg::*;
;
  localparam logic [63:0] CLR = 64'h0000_0000_ffff_0000;
  logic        mclk = 0, resetn = 0, recovery_resetn = 1, arch_v11_pin = 0, fire = 0;
  ersl_acc_s   acc = '0;
  ersl_event_s req = '0, err_event;
  logic [63:0] rd_data;
  logic        rd_valid, wr_ignored, record_valid, overflow, sys_error_pin;
  int          err_count = 0, checked = 0;
  always #2 mclk = ~mclk;
  ersl_err_src ersl_err_src_i (.fire(fire), .req(req), .err_event(err_event));
  ersl_record ersl_record_i (
    .mclk(mclk), .resetn(resetn), .recovery_resetn(recovery_resetn),
    .arch_v11_pin(arch_v11_pin), .acc(acc), .err_event(err_event), .rd_data(rd_data),
    .rd_valid(rd_valid), .wr_ignored(wr_ignored), .record_valid(record_valid),
    .overflow(overflow), .sys_error_pin(sys_error_pin)
  );
  task summarize;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task op(input logic av, input logic w, input logic [11:0] a, input logic [63:0] d,
          input logic f);
    @(posedge mclk);
    #1 acc = '{av, w, a, d};
    fire = f;
    @(posedge mclk);
    #1 acc.valid = 0;
    fire = 0;
  endtask
  task rd(input logic [11:0] a, input logic [63:0] e);
    op(1, 0, a, '0, 0);
    chk("rd_valid", rd_valid, 1);
    chk("rd_data", rd_data, e);
  endtask
  task ev(input logic ue, input logic [1:0] ce, input logic [7:0] code, input logic av);
    req = '0;
    req.uncorrected = ue;
    req.corrected_kind = ce;
    req.primary_code = code;
    req.impl_subcode = ~code;
    op(av, 1, 12'h010, CLR, 1);
  endtask
  function logic [63:0] st(input logic ue, input logic ovf, input logic [1:0] ce,
                           input logic [7:0] code);
    ersl_status_s s;
    s = '0;
    s.record_valid = 1;
    s.uncorrected_flag = ue;
    s.overflow_flag = ovf;
    s.corrected_kind = ce;
    s.primary_code = code;
    s.impl_subcode = ~code;
    return s;
  endfunction
  initial begin
    #100000 err_count++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 resetn = 1;
    rd(12'h010, 64'h0);
    rd(12'hff0, 64'h0000_0000_0000_000d);
    op(1, 1, 12'hff0, '1, 0);
    rd(12'hff0, 64'h0000_0000_0000_000d);
    rd(12'h100, 64'h0);
    op(1, 1, 12'h010, 64'h1234_5678_ffff_abcd, 0);
    rd(12'h010, 64'h1234_5678_0000_abcd);
    op(1, 1, 12'h010, 64'h0, 0);
    for (int c = 0; c <= 26; c++) begin
      ev(0, c[1:0], c[7:0], 0);
      rd(12'h010, st(0, 0, c[1:0], c[7:0]));
      op(1, 1, 12'h010, CLR, 0);
      rd(12'h010, 64'h0);
    end
    ev(0, 2'b01, 8'h06, 0);
    ev(0, 2'b01, 8'h06, 0);
    chk("overflow", overflow, 1);
    chk("record_valid", record_valid, 1);
    op(1, 1, 12'h010, 64'h0000_0000_4300_0000, 0);
    rd(12'h010, st(0, 1, 2'b01, 8'h06));
    op(1, 1, 12'h010, 64'h0000_0000_0b00_0000, 0);
    rd(12'h010, 64'h0000_0000_4000_0000);
    op(1, 1, 12'h010, CLR, 0);
    arch_v11_pin = 1;
    repeat (6) @(posedge mclk);
    ev(1, 2'b00, 8'h05, 0);
    chk("sys_error_pin", sys_error_pin, 1);
    op(1, 1, 12'h010, 64'h0000_0000_4000_0000, 0);
    chk("wr_ignored", wr_ignored, 1);
    rd(12'h010, st(1, 0, 2'b00, 8'h05));
    op(1, 1, 12'h010, 64'h0000_0000_6000_0033, 0);
    chk("wr_ignored", wr_ignored, 0);
    rd(12'h010, 64'h0000_0000_0000_0033);
    chk("record_valid", record_valid, 0);
    ev(0, 2'b11, 8'h07, 1);
    rd(12'h010, st(0, 0, 2'b11, 8'h07));
    @(posedge mclk);
    #1 recovery_resetn = 0;
    ev(1, 2'b00, 8'h11, 0);
    recovery_resetn = 1;
    chk("sys_error_pin", sys_error_pin, 0);
    rd(12'h010, st(0, 0, 2'b11, 8'h07));
    summarize;
  end
endmodule
`default_nettype wire
